// ### design/csd_top.sv
/*
 * clock source and divider control: source select, wake-up gate,
 * cpu clock divider, peripheral clock, clock-out pin, rc tuning and
 * low power select, with an ahb-lite register slave.
 * assumes oscillator inputs are asynchronous to clk, and that
 * configuration, power_down, rtc_on_crystal and sys_reset_n come
 * from logic on clk.
 */
// Overview of operation
// R1: one of four sources, fixed by configuration
// R2: cpu clock divided from oscillator, up to 510
// R3: divider value changes anytime without glitching; a change to zero ending a high half leaves a one-cycle low runt
// R4: machine cycle spans two cpu clock cycles
// R5: peripheral clock is half the cpu clock
// R6: crystal sources wait 992 cycles plus settle
// R7: other sources wait 224 cycles plus settle
// R8: clock out only when enabled, crystal unused
// R9: clock out runs at half cpu clock
// R10: six-bit writable rc tuning field
// R11: tuning loads factory value on power-on only
// R12: every reset clears low power select
// R13: three crystal ranges chosen by configuration
// R14: software keeps cpu clock at most 12 MHz
// R15: ratio twice divider value, zero passes through
// R16: wake timer gates cpu clock after power-up
`timescale 1ns/10ps
`include "csd_map.svh"

module csd_top import csd_pkg::*; #(
  parameter logic [5:0] FACTORY_TRIM = `CSD_TRIM_FACTORY,
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sys_reset_n,
  input wire csd_cfg_t cfg,
  input wire logic power_down,
  input wire logic rtc_on_crystal,
  input wire logic wdt_osc_clk,
  input wire logic rc_osc_clk,
  input wire logic xtal_osc_clk,
  input wire logic crystal_in_pin,
  input wire logic crystal_out_clock_pin_i,
  output logic crystal_out_clock_pin_o,
  output logic crystal_out_clock_pin_oe_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [5:0] rc_tune_field,
  output logic low_power_clock_select,
  output logic oscillator_clock,
  output logic wake_busy,
  output csd_clocks_t clocks
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [4:0] pin_raw; // asynchronous levels
  logic [4:0] pin_meta_q; // first stage, read only by second
  logic [4:0] pin_sync_q; // safe levels

  assign pin_raw = {crystal_out_clock_pin_i, crystal_in_pin,
                    xtal_osc_clk, rc_osc_clk, wdt_osc_clk};

  // one two-flop chain per source; the mux looks only at stage two
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_meta_q[gi] <= 1'b0;
          pin_sync_q[gi] <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // configuration capture and source select
  // ****************************************************************
  csd_cfg_t cfg_q, cfg_d; // held configuration
  logic cfg_taken_q, cfg_taken_d; // set once after reset release
  logic osc_level; // selected, synchronised source
  logic osc_prev_q, osc_prev_d; // last oscillator level
  logic osc_rise; // oscillator rising mark
  logic pd_prev_q, pd_prev_d; // last power_down level
  logic wake_start; // restart the wake timer

  // configuration is taken once, in the first cycle after release,
  // so a changing strap cannot switch sources under the cpu
  always_comb begin
    cfg_d = cfg_q;
    cfg_taken_d = 1'b1;
    if (!cfg_taken_q) begin
      cfg_d = cfg; // R1 R13
    end
    osc_prev_d = osc_level;
    pd_prev_d = power_down;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= '{source: CSD_SRC_RC, range: CSD_RNG_LOW};
      cfg_taken_q <= 1'b0;
      osc_prev_q <= 1'b0;
      pd_prev_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      cfg_taken_q <= cfg_taken_d;
      osc_prev_q <= osc_prev_d;
      pd_prev_q <= pd_prev_d;
    end
  end

  // wdt, rc, crystal and external input sit at index = source code
  assign osc_level = pin_sync_q[cfg_q.source]; // R1
  assign osc_rise = osc_level & ~osc_prev_q;
  // timer restarts when the source is known and on power-down exit
  assign wake_start = ~cfg_taken_q | (pd_prev_q & ~power_down);

  // ****************************************************************
  // wake-up timer and divider
  // ****************************************************************
  logic cpu_level; // divided cpu clock
  logic cpu_rise; // cpu rising mark
  logic run; // cpu clock allowed
  logic [DIV_W-1:0] div_val_q, div_val_d; // clock_divider_value

  csd_wakeup u_wakeup (
    .clk(clk),
    .reset_n(reset_n),
    .start(wake_start),
    .osc_rise(osc_rise),
    .crystal(cfg_q.source == CSD_SRC_XTAL),
    .busy(wake_busy)
  );

  // cpu clock stays off while the timer or power-down holds it
  assign run = ~wake_busy & ~power_down; // R16

  csd_divider #(
    .W(DIV_W)
  ) u_divider (
    .clk(clk),
    .reset_n(reset_n),
    .run(run),
    .osc_level(osc_level),
    .osc_rise(osc_rise),
    .div_val(div_val_q),
    .cpu_level(cpu_level),
    .cpu_rise(cpu_rise)
  );

  // ****************************************************************
  // registers and ahb-lite slave
  // ****************************************************************
  logic [5:0] trim_q, trim_d; // rc tuning
  logic cko_en_q, cko_en_d; // clock_out_enable
  logic lp_q, lp_d; // low_power_clock_select
  logic dph_valid_q, dph_valid_d; // data phase pending
  logic dph_write_q, dph_write_d; // pending is a write
  logic [7:0] dph_addr_q, dph_addr_d; // pending byte offset
  logic wr; // write lands this cycle

  // the slave never stalls; only the low address byte is decoded,
  // so the map repeats every 256 bytes inside its select
  assign wr = dph_valid_q & dph_write_q & sys_reset_n;

  always_comb begin
    dph_valid_d = hsel & htrans[1] & hready;
    dph_write_d = hwrite;
    dph_addr_d = haddr[7:0];
    trim_d = trim_q;
    cko_en_d = cko_en_q;
    div_val_d = div_val_q;
    lp_d = lp_q;
    if (!sys_reset_n) begin // other resets leave tuning alone
      div_val_d = DIV_W'(`CSD_DIV_RST); // R11
      lp_d = 1'b0; // R12
    end else if (wr) begin
      case (dph_addr_q)
        `CSD_OFS_TRIM: begin
          trim_d = hwdata[`CSD_TRIM_MSB:0]; // R10
          cko_en_d = hwdata[`CSD_CKO_EN_BIT];
        end
        `CSD_OFS_DIV: div_val_d = hwdata[DIV_W-1:0]; // R3
        // lp is only safe at 8 MHz cpu or below, software's duty
        `CSD_OFS_AUX1: lp_d = hwdata[`CSD_LP_BIT]; // R12
        default: ; // read-only and unmapped writes ignored
      endcase
    end
  end

  // power-on reset alone loads the factory tuning value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_q <= FACTORY_TRIM; // R11
      cko_en_q <= 1'b0;
      div_val_q <= DIV_W'(`CSD_DIV_RST);
      lp_q <= 1'b0; // R12
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q <= 8'h00;
    end else begin
      trim_q <= trim_d;
      cko_en_q <= cko_en_d;
      div_val_q <= div_val_d;
      lp_q <= lp_d;
      dph_valid_q <= dph_valid_d;
      dph_write_q <= dph_write_d;
      dph_addr_q <= dph_addr_d;
    end
  end

  // read mux in the data phase; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dph_valid_q && !dph_write_q) begin
      case (dph_addr_q)
        `CSD_OFS_TRIM: begin
          hrdata[`CSD_TRIM_MSB:0] = trim_q;
          hrdata[`CSD_CKO_EN_BIT] = cko_en_q;
        end
        `CSD_OFS_DIV: hrdata[DIV_W-1:0] = div_val_q;
        `CSD_OFS_AUX1: hrdata[`CSD_LP_BIT] = lp_q;
        `CSD_OFS_STAT: begin
          hrdata[`CSD_ST_BUSY_BIT] = wake_busy;
          hrdata[`CSD_ST_PD_BIT] = power_down;
          hrdata[`CSD_ST_SRC_LSB +: 2] = cfg_q.source;
          hrdata[`CSD_ST_RNG_LSB +: 2] = cfg_q.range;
          hrdata[`CSD_ST_PIN_BIT] = pin_sync_q[4];
        end
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************************************
  // peripheral clock, machine cycle and clock-out pin
  // ****************************************************************
  logic periph_q, periph_d; // cpu clock over two
  logic mc_q, mc_d; // machine cycle start mark
  logic pin_o_q, pin_o_d; // clock-out level
  logic oe_n_q, oe_n_d; // clock-out enable, low drives
  logic clkout_ok; // clock-out may run

  // clock-out would fight the crystal, so it is barred whenever the
  // crystal drives the cpu or the real-time clock
  assign clkout_ok = cko_en_q & (cfg_q.source != CSD_SRC_XTAL)
                     & ~rtc_on_crystal; // R8

  always_comb begin
    periph_d = cpu_rise ? ~periph_q : periph_q; // R5
    mc_d = cpu_rise & ~periph_q; // R4
    pin_o_d = clkout_ok & periph_q; // R9
    oe_n_d = ~clkout_ok; // R8
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_q <= 1'b0;
      mc_q <= 1'b0;
      pin_o_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      periph_q <= periph_d;
      mc_q <= mc_d;
      pin_o_q <= pin_o_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign crystal_out_clock_pin_o = pin_o_q;
  assign crystal_out_clock_pin_oe_n = oe_n_q;
  assign rc_tune_field = trim_q;
  assign low_power_clock_select = lp_q;
  assign oscillator_clock = osc_level;
  assign clocks = '{cpu_clock: cpu_level, peripheral_clock: periph_q,
                    machine_cycle: mc_q};

  // ****************************************************************
  // checks
  // ****************************************************************
  a_src_fixed: assert property ( // R1
    @(posedge clk) disable iff (!reset_n)
    cfg_taken_q |=> $stable(cfg_q))
    else $error("clock source changed after capture");

  a_div_write: assert property ( // R2
    @(posedge clk) disable iff (!reset_n)
    wr && dph_addr_q == `CSD_OFS_DIV |=> div_val_q == $past(hwdata[7:0]))
    else $error("divider value write lost");

  a_machine_cycle: assert property ( // R4
    @(posedge clk) disable iff (!reset_n)
    mc_q |-> periph_q && !$past(periph_q))
    else $error("machine cycle mark off peripheral rise");

  a_periph_half: assert property ( // R5
    @(posedge clk) disable iff (!reset_n)
    cpu_rise |=> periph_q != $past(periph_q))
    else $error("peripheral clock missed a cpu rise");

  a_clkout_gate: assert property ( // R8
    @(posedge clk) disable iff (!reset_n)
    !crystal_out_clock_pin_oe_n |-> $past(cko_en_q)
      && !$past(rtc_on_crystal) && $past(cfg_q.source) != CSD_SRC_XTAL)
    else $error("clock out driven while barred");

  a_clkout_half: assert property ( // R9
    @(posedge clk) disable iff (!reset_n)
    !crystal_out_clock_pin_oe_n |-> pin_o_q == $past(periph_q))
    else $error("clock out not at half cpu clock");

  a_trim_write: assert property ( // R10
    @(posedge clk) disable iff (!reset_n)
    wr && dph_addr_q == `CSD_OFS_TRIM |=> trim_q == $past(hwdata[5:0]))
    else $error("tuning write lost");

  a_trim_keep: assert property ( // R11
    @(posedge clk) disable iff (!reset_n)
    !sys_reset_n |=> $stable(trim_q))
    else $error("tuning changed by a non power-on reset");

  a_lp_clear: assert property ( // R12
    @(posedge clk) disable iff (!reset_n)
    !sys_reset_n |=> !lp_q)
    else $error("low power select survived reset");

  a_cpu_gated: assert property ( // R16
    @(posedge clk) disable iff (!reset_n)
    wake_busy |=> !cpu_level)
    else $error("cpu clock ran during wake-up");

endmodule : csd_top

// ### design/csd_map.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the clock source and divider control block.
 * assumes a 20 MHz system clock and a 32-bit ahb-lite register bus.
 */
`ifndef CSD_MAP_SVH
`define CSD_MAP_SVH

// ****************************************************************
// register byte offsets (one aligned word each)
// ****************************************************************
`define CSD_OFS_TRIM 8'h00
`define CSD_OFS_DIV 8'h04
`define CSD_OFS_AUX1 8'h08
`define CSD_OFS_STAT 8'h0c

// ****************************************************************
// field positions
// ****************************************************************
`define CSD_TRIM_MSB 5
`define CSD_CKO_EN_BIT 6
`define CSD_LP_BIT 7
`define CSD_ST_BUSY_BIT 0
`define CSD_ST_PD_BIT 1
`define CSD_ST_SRC_LSB 2
`define CSD_ST_RNG_LSB 4
`define CSD_ST_PIN_BIT 6

// ****************************************************************
// reset values
// ****************************************************************
// factory tuning value is arbitrary here, real parts fuse their own
`define CSD_TRIM_FACTORY 6'h20
`define CSD_DIV_RST 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define CSD_CLK_PERIOD_NS 50
// least settle time after the oscillator count, in ns
`define CSD_WAKE_NS 60000
`define CSD_WAKE_CYC \
  ((`CSD_WAKE_NS + `CSD_CLK_PERIOD_NS - 1) / `CSD_CLK_PERIOD_NS)
`define CSD_XTAL_OSC_CYC 992
`define CSD_OTHER_OSC_CYC 224
// largest division ratio, twice the biggest 8-bit divider value
`define CSD_MAX_RATIO 510

`endif

// ### design/csd_pkg.sv
/*
 * shared types of the clock source and divider control block.
 * assumes nothing of its surroundings.
 */
package csd_pkg;

  // oscillator clock source, fixed by nonvolatile configuration
  typedef enum logic [1:0] {
    CSD_SRC_WDT = 2'b00,
    CSD_SRC_RC = 2'b01,
    CSD_SRC_XTAL = 2'b10,
    CSD_SRC_EXT = 2'b11
  } csd_src_t;

  // crystal range: 20-100 kHz, 100 kHz-4 MHz, 4-12 MHz
  typedef enum logic [1:0] {
    CSD_RNG_LOW = 2'b00,
    CSD_RNG_MED = 2'b01,
    CSD_RNG_HIGH = 2'b10
  } csd_range_t;

  // wake-up timer states
  typedef enum logic [1:0] {
    CSD_WK_IDLE = 2'b00,
    CSD_WK_OSC = 2'b01,
    CSD_WK_SETTLE = 2'b10
  } csd_wake_t;

  // configuration word
  typedef struct packed {
    csd_src_t source;
    csd_range_t range;
  } csd_cfg_t;

  // derived clocks leaving the block
  typedef struct packed {
    logic cpu_clock;
    logic peripheral_clock;
    logic machine_cycle;
  } csd_clocks_t;

endpackage : csd_pkg

// ### design/csd_divider.sv
/*
 * cpu clock divider: ratio twice the divider value, zero passes the
 * oscillator level through.
 * assumes osc_level and osc_rise are already synchronised to clk.
 */
`timescale 1ns/10ps
`include "csd_map.svh"

module csd_divider #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic osc_level,
  input wire logic osc_rise,
  input wire logic [W-1:0] div_val,
  output logic cpu_level,
  output logic cpu_rise
);

  logic [W-1:0] div_q, div_d; // ratio in use
  logic [W-1:0] cnt_q, cnt_d; // oscillator edges in this half
  logic cpu_q, cpu_d; // cpu clock level
  logic rise_q, rise_d; // one-cycle cpu rising mark

  // ****************************************************************
  // next state
  // ****************************************************************
  // new ratio is only taken at a half-period boundary, so a write
  // never makes a runt pulse, except zero taken as a high half ends
  always_comb begin
    div_d = div_q;
    cnt_d = cnt_q;
    cpu_d = cpu_q;
    if (!run) begin // gated: hold low
      cpu_d = 1'b0;
      cnt_d = '0;
      div_d = div_val;
    end else if (div_q == '0) begin // pass through
      cpu_d = osc_level; // R15
      if (osc_rise) begin
        div_d = div_val; // R3
      end
    end else if (osc_rise) begin
      if (cnt_q == div_q - W'(1)) begin // half period done
        cnt_d = '0;
        cpu_d = ~cpu_q; // R2
        div_d = div_val; // R3
      end else begin
        cnt_d = cnt_q + W'(1);
      end
    end
    rise_d = cpu_d & ~cpu_q;
  end

  // registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      cnt_q <= '0;
      cpu_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      cpu_q <= cpu_d;
      rise_q <= rise_d;
    end
  end

  assign cpu_level = cpu_q;
  assign cpu_rise = rise_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_cnt_bound: assert property ( // R15
    @(posedge clk) disable iff (!reset_n)
    div_q != '0 |-> cnt_q < div_q)
    else $error("divider count beyond ratio");

  a_ratio_edge: assert property ( // R3
    @(posedge clk) disable iff (!reset_n)
    $past(run) && run && $changed(div_q)
      |-> ($past(div_q) == '0) || (cpu_q != $past(cpu_q)))
    else $error("ratio changed mid half period");

endmodule : csd_divider

// ### design/csd_wakeup.sv
/*
 * wake-up timer: counts oscillator edges, then a fixed settle time,
 * holding the cpu clock off meanwhile.
 * assumes osc_rise is a one-cycle mark already on clk.
 */
`timescale 1ns/10ps
`include "csd_map.svh"

module csd_wakeup import csd_pkg::*; #(
  parameter int XTAL_CYC = `CSD_XTAL_OSC_CYC,
  parameter int OTHER_CYC = `CSD_OTHER_OSC_CYC,
  parameter int SETTLE_CYC = `CSD_WAKE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic osc_rise,
  input wire logic crystal,
  output logic busy
);

  csd_wake_t state_q, state_d; // timer phase
  logic [9:0] osc_cnt_q, osc_cnt_d; // oscillator edges seen
  logic [10:0] set_cnt_q, set_cnt_d; // settle cycles seen
  logic [9:0] osc_last; // last edge index for the source

  assign osc_last = crystal ? 10'(XTAL_CYC - 1) : 10'(OTHER_CYC - 1);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    osc_cnt_d = osc_cnt_q;
    set_cnt_d = set_cnt_q;
    case (state_q)
      CSD_WK_IDLE: begin
        osc_cnt_d = '0;
      end
      CSD_WK_OSC: begin // R6
        if (osc_rise) begin
          if (osc_cnt_q == osc_last) begin // R7
            state_d = CSD_WK_SETTLE;
            set_cnt_d = '0;
          end else begin
            osc_cnt_d = osc_cnt_q + 10'h001;
          end
        end
      end
      CSD_WK_SETTLE: begin
        if (set_cnt_q == 11'(SETTLE_CYC - 1)) begin
          state_d = CSD_WK_IDLE;
        end else begin
          set_cnt_d = set_cnt_q + 11'h001;
        end
      end
      default: state_d = CSD_WK_IDLE;
    endcase
    if (start) begin // restart wins over any phase
      state_d = CSD_WK_OSC; // R16
      osc_cnt_d = '0;
    end
  end

  // registers only; power-up begins counting at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CSD_WK_OSC;
      osc_cnt_q <= '0;
      set_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      osc_cnt_q <= osc_cnt_d;
      set_cnt_q <= set_cnt_d;
    end
  end

  assign busy = (state_q != CSD_WK_IDLE);

  // ****************************************************************
  // checks
  // ****************************************************************
  a_xtal_count: assert property ( // R6
    @(posedge clk) disable iff (!reset_n)
    state_q == CSD_WK_OSC && osc_rise && crystal && !start
      && osc_cnt_q == 10'd991 |=> state_q == CSD_WK_SETTLE)
    else $error("crystal wake count not 992");

  a_other_count: assert property ( // R7
    @(posedge clk) disable iff (!reset_n)
    state_q == CSD_WK_OSC && !crystal && osc_cnt_q > 10'd223
      |-> 1'b0)
    else $error("non-crystal wake count beyond 224");

  a_settle_len: assert property ( // R16
    @(posedge clk) disable iff (!reset_n)
    state_q == CSD_WK_SETTLE && !start && set_cnt_q == 11'd1199
      |=> state_q == CSD_WK_IDLE)
    else $error("settle time not 1200 cycles");

endmodule : csd_wakeup

// ### dv/csd_osc_model.sv
/*
 * oscillator sources on the far side of the clock control block.
 * assumes the block samples them with a much faster system clock.
 */
`timescale 1ns/10ps

module csd_osc_model #(
  parameter int WDT_HALF = 500,
  parameter int RC_HALF = 400,
  parameter int XTAL_HALF = 400,
  parameter int EXT_HALF = 300
) (
  output logic wdt_osc_clk,
  output logic rc_osc_clk,
  output logic xtal_osc_clk,
  output logic ext_clk
);
  // ****************************************************************
  // free-running sources
  // ****************************************************************
  // wdt, rc and external rates differ, so a wrong source choice shows in the wake time
  initial begin
    wdt_osc_clk = 1'b0;
    rc_osc_clk = 1'b0;
    xtal_osc_clk = 1'b0;
    ext_clk = 1'b0;
  end
  always #(WDT_HALF) wdt_osc_clk = !wdt_osc_clk;
  always #(RC_HALF) rc_osc_clk = !rc_osc_clk;
  // 1.25 MHz crystal, inside the medium range
  always #(XTAL_HALF) xtal_osc_clk = !xtal_osc_clk;
  always #(EXT_HALF) ext_clk = !ext_clk;
endmodule : csd_osc_model

// ### dv/csd_tb.sv
/*
 * self-checking bench: bus tasks, ratio counters, read scoreboard.
 * assumes the oscillator model runs far below clk.
 */
`timescale 1ns/10ps
`include "csd_map.svh"

module clock_source_divider_control_tb_top import csd_pkg::*; ();
  logic clk, reset_n, sys_reset_n, power_down, rtc_on_crystal;
  logic hsel, hwrite, hreadyout, hresp, pin_o, pin_oe_n, lp, osc, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [5:0] tune, t;
  logic [7:0] dv [5];
  csd_cfg_t cfg;
  csd_clocks_t clks;
  logic wdt, rc, xt, ext, pin_i;
  logic rdp = 1'b0, po = 1'b0, pc = 1'b0, pp = 1'b0, pk = 1'b0;
  logic [2:0] ev = 3'h0;
  int n_mismatch, n_tests, cyc, wk, n_osc, n_cpu, n_mc, n_pk;
  int l_osc, l_cpu, l_mc, l_pk;
  logic [31:0] expq [$];
  // edge marks of the watched clocks
  wire cr = clks.cpu_clock & !pc;
  wire prr = clks.peripheral_clock & !pp;
  // pin level: block drives it when oe_n low, else the crystal when it
  // is the source, else the port pull-up
  assign pin_i = pin_oe_n ? (cfg.source == CSD_SRC_XTAL ? xt : 1'b1)
                          : pin_o;

  csd_osc_model osc_m (.wdt_osc_clk(wdt), .rc_osc_clk(rc),
    .xtal_osc_clk(xt), .ext_clk(ext));

  csd_top DUT (.clk(clk), .reset_n(reset_n), .sys_reset_n(sys_reset_n),
    .cfg(cfg), .power_down(power_down), .rtc_on_crystal(rtc_on_crystal),
    .wdt_osc_clk(wdt), .rc_osc_clk(rc), .xtal_osc_clk(xt),
    .crystal_in_pin(ext), .crystal_out_clock_pin_i(pin_i),
    .crystal_out_clock_pin_o(pin_o),
    .crystal_out_clock_pin_oe_n(pin_oe_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rc_tune_field(tune), .low_power_clock_select(lp),
    .oscillator_clock(osc), .wake_busy(busy), .clocks(clks));

  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end

  // ****************************************************************
  // compare, verdict, bus tasks
  // ****************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task conclude;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // address phase held until hready, then data phase until hready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    if (!w) expq.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : xfer

  task wait_ev(input int k, input int n);
    repeat (n) begin
      do @(posedge clk); while (ev[k] !== 1'b1);
    end
  endtask : wait_ev

  task por(input csd_src_t s);
    reset_n <= 1'b0;
    cfg <= '{source: s, range: CSD_RNG_MED};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
  endtask : por

  // busy time: n oscillator periods of p clk plus the settle time
  task wake(input int n, input int p);
    do @(posedge clk); while (busy !== 1'b0);
    chk(wk > n * p + 1152 && wk < n * p + 1248, 1);
  endtask : wake

  // ****************************************************************
  // watchers: read scoreboard, ratio counters, timeout
  // ****************************************************************
  always @(posedge clk) begin
    if (rdp) chk(hrdata, expq.pop_front());
    rdp <= hsel & htrans[1] & !hwrite & hreadyout;
    {po, pc, pp, pk} <= {osc, clks.cpu_clock, clks.peripheral_clock, pin_o};
    ev <= {pin_o & !pk, prr, cr};
    n_osc <= (cr ? 0 : n_osc) + (osc & !po);
    n_cpu <= (prr ? 0 : n_cpu) + cr;
    n_mc <= (prr ? 0 : n_mc) + clks.machine_cycle;
    n_pk <= ((pin_o & !pk) ? 0 : n_pk) + cr;
    if (cr) l_osc <= n_osc;
    if (prr) {l_cpu, l_mc} <= {n_cpu, n_mc};
    if (pin_o & !pk) l_pk <= n_pk;
    wk <= (!reset_n | power_down) ? 0 : wk + busy;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_mismatch++;
      conclude;
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {reset_n, power_down, rtc_on_crystal, hsel, hwrite} = 5'h0;
    {sys_reset_n, htrans, hsize} = 6'b100010;
    {haddr, hwdata} = 64'h0;
    cfg = '{source: CSD_SRC_RC, range: CSD_RNG_MED};
    void'($urandom(32'h51a38fd9));
    t = 6'($urandom_range(0, 63));
    dv = '{8'h01, 8'h03, 8'($urandom_range(2, 9)), 8'hff, 8'h00};
    por(CSD_SRC_RC);
    xfer(0, `CSD_OFS_TRIM, {26'h0, `CSD_TRIM_FACTORY});
    xfer(0, `CSD_OFS_DIV, 32'h0);
    xfer(0, 8'h10, 32'h0);
    wake(224, 16);
    xfer(1, `CSD_OFS_TRIM, {25'h0, 1'b1, t});
    xfer(0, `CSD_OFS_TRIM, {25'h0, 1'b1, t});
    chk(tune, t);
    wait_ev(2, 3);
    chk(pin_oe_n, 0);
    chk(l_pk, 2);
    rtc_on_crystal <= 1'b1;
    repeat (4) @(posedge clk);
    chk(pin_oe_n, 1);
    // released pin reads its pull-up; source and range as captured
    xfer(0, `CSD_OFS_STAT,
      {25'h0, 1'b1, CSD_RNG_MED, CSD_SRC_RC, 2'b00});
    rtc_on_crystal <= 1'b0;
    // ratios stay slow, far below the cpu clock ceiling
    foreach (dv[i]) begin
      xfer(1, `CSD_OFS_DIV, {24'h0, dv[i]});
      wait_ev(0, 2);
      chk(l_osc, dv[i] == 8'h00 ? 1 : 2 * dv[i]);
      wait_ev(1, 2);
      chk(l_cpu, 2);
      chk(l_mc, 1);
    end
    xfer(1, `CSD_OFS_AUX1, 32'h80);
    xfer(1, `CSD_OFS_DIV, 32'h5);
    xfer(0, `CSD_OFS_AUX1, 32'h80);
    sys_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    sys_reset_n <= 1'b1;
    @(posedge clk);
    chk(lp, 0);
    xfer(0, `CSD_OFS_AUX1, 32'h0);
    xfer(0, `CSD_OFS_TRIM, {25'h0, 1'b1, t});
    power_down <= 1'b1;
    repeat (8) @(posedge clk);
    chk(clks.cpu_clock, 0);
    power_down <= 1'b0;
    repeat (3) @(posedge clk);
    chk(busy, 1);
    wake(224, 16);
    por(CSD_SRC_WDT);
    wake(224, 20);
    por(CSD_SRC_EXT);
    wake(224, 12);
    por(CSD_SRC_XTAL);
    xfer(0, `CSD_OFS_TRIM, {26'h0, `CSD_TRIM_FACTORY});
    xfer(1, `CSD_OFS_TRIM, 32'h40);
    wake(992, 16);
    chk(pin_oe_n, 1);
    conclude;
  end
endmodule : clock_source_divider_control_tb_top
